// File: rtl/asf_pkg.sv
package asf_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam logic [7:0] ADDR_BUFFER_SETUP = 8'h09;
  localparam logic [7:0] BUFFER_SETUP_RESET = 8'h00;
  localparam int MODE_LSB = 6;
  localparam int WMRK_LSB = 0;

  // ************************************************************
  // Sizes and counts
  // ************************************************************
  localparam int AXIS_W = 16;
  localparam int STORE_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int STAGE_DEPTH = 16;
  localparam logic [CNT_W-1:0] STORE_FULL = 6'h20;
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [1:0] AXIS_Y = 2'h1;
  localparam logic [1:0] AXIS_Z = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_CIRCULAR = 2'h1,
    MODE_STOP = 2'h2,
    MODE_TRIGGER = 2'h3
  } asf_mode_t;

  typedef struct packed {
    asf_mode_t mode;
    logic [5:0] wmrk;
  } asf_setup_t;

  typedef struct packed {
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
  } asf_sample_t;

  localparam int SAMPLE_W = $bits(asf_sample_t);

  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_FILL = 3'h2,
    ST_POST = 3'h4
  } asf_state_t;

endpackage

// File: rtl/asf_stage_fifo.sv
`timescale 1ns/1ns
module asf_stage_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] rdPtr;
  logic [AW-1:0] wrPtr;
  logic [AW:0] used;
  logic doIn;
  logic doOut;
  logic [AW:0] next_used;

  // Handshakes on both sides; ready and valid come from registered state.
  assign doIn = inValid && inReady;
  assign doOut = outValid && outReady;
  assign outData = mem[rdPtr];

  always_comb begin
    next_used = used;
    if (doIn && !doOut) begin
      next_used = used + 1'b1;
    end else if (doOut && !doIn) begin
      next_used = used - 1'b1;
    end
  end

  // Occupancy, pointers and the registered full and empty views.
  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      rdPtr <= '0;
      wrPtr <= '0;
      used <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (doIn) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doOut) begin
        rdPtr <= rdPtr + 1'b1;
      end
      used <= next_used;
      inReady <= (next_used != DEPTH[AW:0]);
      outValid <= (next_used != '0);
    end
  end

  // Storage carries no reset; only written entries are ever read.
  always_ff @(posedge ref_clk) begin
    if (doIn) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule

// File: rtl/asf_sample_buffer.sv
`timescale 1ns/1ns
module asf_sample_buffer
  import asf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic activeMode,
  input wire logic sleepActive,
  input wire logic normalRateTick,
  input wire logic sleepRateTick,
  input wire logic autoRateChange,
  input wire asf_sample_t accelSample,
  input wire logic triggerEvent,
  input wire logic hostRead,
  input wire logic burstEnd,
  output logic [AXIS_W-1:0] axisData,
  output logic axisValid,
  output logic [CNT_W-1:0] sampleCount,
  output logic overflowFlag,
  output logic watermarkFlag,
  output logic triggerSeen,
  output logic sampleStalled
);

  // ************************************************************
  // Declarations
  // ************************************************************
  asf_setup_t setup;
  asf_state_t state;
  asf_sample_t store [0:STORE_DEPTH-1];
  asf_sample_t pendSample;
  asf_sample_t stageData;
  logic [PTR_W-1:0] headPtr;
  logic [PTR_W-1:0] tailPtr;
  logic [CNT_W-1:0] count;
  logic [1:0] axisSel;
  logic activePrev;
  logic pending;
  logic stageReady;
  logic stageValid;
  logic drainReady;
  logic setupHit;
  logic modeWrite;
  logic modeLegal;
  logic disableWrite;
  logic flush;
  logic rateTick;
  logic storeFull;
  logic overwrite;
  logic pushNow;
  logic keepPush;
  logic trigHit;
  logic trimNow;
  logic readOk;
  logic popNow;
  logic [CNT_W-1:0] trimAmt;

  // Picks one axis of the head sample for the host.
  function automatic logic [AXIS_W-1:0] pick_axis(input asf_sample_t s,
                                                  input logic [1:0] sel);
    logic [AXIS_W-1:0] v;
    v = s.x;
    if (sel == AXIS_Y) begin
      v = s.y;
    end else if (sel == AXIS_Z) begin
      v = s.z;
    end
    return v;
  endfunction

  // ************************************************************
  // Setup register
  // ************************************************************

  // Decode of the setup register write and the mode-change guard.
  assign setupHit = regWrite && (regAddr == ADDR_BUFFER_SETUP);
  assign modeLegal = (regWrData[MODE_LSB+:2] == MODE_OFF)
                  || (setup.mode == MODE_OFF)
                  || (regWrData[MODE_LSB+:2] == setup.mode);
  assign modeWrite = setupHit && modeLegal;
  assign disableWrite = modeWrite && (regWrData[MODE_LSB+:2] == MODE_OFF);

  // Mode is taken in any power state, the watermark only in standby.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      setup <= asf_setup_t'(BUFFER_SETUP_RESET);
    end else begin
      if (modeWrite) begin
        setup.mode <= asf_mode_t'(regWrData[MODE_LSB+:2]);
      end
      if (setupHit && !activeMode) begin
        setup.wmrk <= regWrData[WMRK_LSB+:6];
      end
    end
  end

  // Read answer one cycle after the strobe; other addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= (regAddr == ADDR_BUFFER_SETUP) ? 8'(setup) : 8'h00;
    end
  end

  // ************************************************************
  // Flush sources
  // ************************************************************

  // Edge of the standby-to-active transition.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      activePrev <= 1'b0;
    end else begin
      activePrev <= activeMode;
    end
  end

  assign flush = disableWrite || autoRateChange || (activeMode && !activePrev);

  // ************************************************************
  // Sample intake
  // ************************************************************

  // Each tick of the selected rate captures one acceleration sample, except in the off state.
  assign rateTick = sleepActive ? sleepRateTick : normalRateTick;

  // A captured sample waits here while the staging queue is full, so a
  // stalled drain really backs up; a later tick replaces the waiting one.
  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      pending <= 1'b0;
      pendSample <= '0;
    end else if (rateTick && (state != ST_OFF)) begin
      pending <= 1'b1;
      pendSample <= accelSample;
    end else if (stageReady) begin
      pending <= 1'b0;
    end
  end

  // Flags a captured sample that the staging queue cannot yet take.
  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      sampleStalled <= 1'b0;
    end else begin
      sampleStalled <= pending && !stageReady;
    end
  end

  asf_stage_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(flush),
    .inValid(pending),
    .inReady(stageReady),
    .inData(pendSample),
    .outValid(stageValid),
    .outReady(drainReady),
    .outData(stageData)
  );

  // ************************************************************
  // Store control
  // ************************************************************

  // The drain waits on host pops and trigger trims so that only one
  // pointer update happens per cycle.
  // A trigger with a zero watermark keeps every stored sample, since a
  // zero setting means no pre-trigger depth was asked for.
  assign storeFull = (count == STORE_FULL);
  assign trigHit = triggerEvent && (state == ST_FILL) && (setup.mode == MODE_TRIGGER);
  assign trimNow = trigHit && (setup.wmrk != 6'h00) && (count > setup.wmrk);
  assign trimAmt = count - setup.wmrk;
  assign readOk = (count != '0);
  assign popNow = readOk && !trimNow
               && ((hostRead && (axisSel == AXIS_Z))
                   || (burstEnd && (axisSel != AXIS_X)));
  assign drainReady = (state != ST_OFF) && !flush && !popNow && !trimNow;
  assign pushNow = stageValid && drainReady;

  // Overwrite only before a trigger in circular and trigger modes.
  assign overwrite = (state == ST_FILL)
                  && ((setup.mode == MODE_CIRCULAR) || (setup.mode == MODE_TRIGGER));
  assign keepPush = pushNow && (!storeFull || overwrite);

  // Operating state follows the mode and the trigger.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_OFF;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (setup.mode != MODE_OFF) begin
            state <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (setup.mode == MODE_OFF) begin
            state <= ST_OFF;
          end else if (trigHit && !flush) begin
            state <= ST_POST;
          end
        end
        ST_POST: begin
          if (setup.mode == MODE_OFF) begin
            state <= ST_OFF;
          end else if (flush) begin
            state <= ST_FILL;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // Pointers and occupancy; a full circular push moves head and tail.
  always_ff @(posedge ref_clk) begin
    if (srst || flush || (state == ST_OFF)) begin
      headPtr <= '0;
      tailPtr <= '0;
      count <= '0;
    end else if (trimNow) begin
      headPtr <= headPtr + trimAmt[PTR_W-1:0];
      count <= setup.wmrk;
    end else if (popNow) begin
      headPtr <= headPtr + 1'b1;
      count <= count - 1'b1;
    end else if (keepPush) begin
      tailPtr <= tailPtr + 1'b1;
      if (storeFull) begin
        headPtr <= headPtr + 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // Sample storage; every entry is one whole acceleration sample.
  always_ff @(posedge ref_clk) begin
    if (keepPush) begin
      store[tailPtr] <= stageData;
    end
  end

  // ************************************************************
  // Host read path
  // ************************************************************

  // Axis walk within a sample; a burst end restarts at X of the next.
  // Limitation: a circular overwrite that lands between the X and Z reads
  // of one sample moves the head, so the host gets later axes of the next
  // sample. Hosts that drain before the store fills never meet this.
  always_ff @(posedge ref_clk) begin
    if (srst || flush || trimNow) begin
      axisSel <= AXIS_X;
    end else if (burstEnd) begin
      axisSel <= AXIS_X;
    end else if (hostRead && readOk) begin
      axisSel <= (axisSel == AXIS_Z) ? AXIS_X : axisSel + 2'h1;
    end
  end

  // Read answer; an empty store answers zero and stays put.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      axisData <= '0;
      axisValid <= 1'b0;
    end else begin
      axisValid <= hostRead;
      if (hostRead) begin
        axisData <= readOk ? pick_axis(store[headPtr], axisSel) : '0;
      end
    end
  end

  // ************************************************************
  // Status
  // ************************************************************

  // Count is shown straight from the occupancy register.
  assign sampleCount = count;

  // Overflow is sticky until a flush, a disable or the off state; the forced clear
  // on disable wins, since the flush also drops the count to zero.
  always_ff @(posedge ref_clk) begin
    if (srst || flush || disableWrite || (state == ST_OFF)) begin
      overflowFlag <= 1'b0;
    end else if (count == STORE_FULL) begin
      overflowFlag <= 1'b1;
    end
  end

  // Watermark is a level that follows the count one cycle later.
  always_ff @(posedge ref_clk) begin
    if (srst || disableWrite || (state == ST_OFF)) begin
      watermarkFlag <= 1'b0;
    end else begin
      watermarkFlag <= (setup.wmrk != 6'h00) && (count >= setup.wmrk);
    end
  end

  // Trigger status for the host.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      triggerSeen <= 1'b0;
    end else begin
      triggerSeen <= (state == ST_POST) || (trigHit && !flush);
    end
  end

endmodule

// File: dv/asf_sample_buffer_asserts.sv
`timescale 1ns/1ns
// ************************************************************
// Port checks for the sample buffer
// ************************************************************
module asf_checker
  import asf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic activeMode,
  input wire logic autoRateChange,
  input wire logic hostRead,
  input wire logic [AXIS_W-1:0] axisData,
  input wire logic axisValid,
  input wire logic [CNT_W-1:0] sampleCount,
  input wire logic overflowFlag,
  input wire logic watermarkFlag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic wasActive;
  // Last level of the run control, to spot the wake edge.
  always_ff @(posedge ref_clk) begin
    wasActive <= activeMode;
  end
  wire wake = activeMode && !wasActive;
  wire offWrite = regWrite && regAddr == ADDR_BUFFER_SETUP && regWrData[7:6] == 2'h0;
  // Any write is treated as a possible clear, so flag checks stay safe.
  wire mayClear = regWrite || autoRateChange || wake;
  sequence sq_read;
    hostRead ##1 axisValid;
  endsequence
  sequence sq_cleared;
    (sampleCount == 6'h00 && !overflowFlag) ##1 !watermarkFlag;
  endsequence
  a_read_answer: assert property (hostRead |-> sq_read)
    else $error("read got no answer");
  a_valid_cause: assert property (axisValid |-> $past(hostRead))
    else $error("answer without read");
  a_empty_read: assert property (hostRead && sampleCount == 6'h00 |=> axisData == '0)
    else $error("empty read not zero");
  a_off_clear: assert property (offWrite |=> sq_cleared)
    else $error("disable did not clear");
  a_auto_flush: assert property (autoRateChange |=> sampleCount == 6'h00)
    else $error("rate change kept samples");
  a_wake_flush: assert property (wake |=> sampleCount == 6'h00)
    else $error("wake kept samples");
  a_ovf_full: assert property (sampleCount == STORE_FULL && !mayClear |=> overflowFlag)
    else $error("overflow flag missing");
  a_ovf_hold: assert property (overflowFlag && !mayClear |=> overflowFlag)
    else $error("overflow flag dropped");
  a_wm_nonzero: assert property (watermarkFlag |-> $past(sampleCount) != 6'h00)
    else $error("watermark on empty");
  a_cnt_limit: assert property (sampleCount <= STORE_FULL)
    else $error("count above depth");
  a_cnt_step: assert property (1'b1 |=> sampleCount <= $past(sampleCount) + 6'h01)
    else $error("count jumped");
endmodule

bind asf_sample_buffer asf_checker u_asf_checker (.ref_clk, .srst, .regAddr, .regWrData,
  .regWrite, .activeMode, .autoRateChange, .hostRead, .axisData, .axisValid, .sampleCount,
  .overflowFlag, .watermarkFlag);

// File: dv/asf_host_model.sv
`timescale 1ns/1ns
// ************************************************************
// Host that drains the buffer axis by axis
// ************************************************************
module asf_host_model
  import asf_pkg::*;
(
  input wire logic ref_clk,
  output logic hostRead,
  output logic burstEnd,
  input wire logic [AXIS_W-1:0] axisData,
  input wire logic axisValid
);
  logic [AXIS_W-1:0] got[$];
  // Idle until a burst is asked for.
  initial begin
    hostRead = 1'b0;
    burstEnd = 1'b0;
  end
  // Reads n axes; fewer than three closes the burst early.
  task automatic rd(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      hostRead <= 1'b1;
      @(posedge ref_clk);
      hostRead <= 1'b0;
      @(negedge ref_clk);
      if (axisValid === 1'b1) got.push_back(axisData);
      @(posedge ref_clk);
      repeat (gap) @(posedge ref_clk);
    end
    if (n < 3) begin
      burstEnd <= 1'b1;
      @(posedge ref_clk);
      burstEnd <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
endmodule

// File: dv/asf_sample_buffer_tb_top.sv
`timescale 1ns/1ns
// ************************************************************
// Self-checking bench for the sample buffer
// ************************************************************
module asf_sample_buffer_tb_top
  import asf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic activeMode = 1'b0;
  logic sleepActive = 1'b0;
  logic normalRateTick = 1'b0;
  logic sleepRateTick = 1'b0;
  logic autoRateChange = 1'b0;
  logic triggerEvent = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  asf_sample_t accelSample = '0;
  logic hostRead, burstEnd, axisValid, overflowFlag, watermarkFlag, triggerSeen, sampleStalled;
  logic [AXIS_W-1:0] axisData;
  logic [CNT_W-1:0] sampleCount;
  int fails = 0;
  int testsRun = 0;
  int cycles = 0;
  asf_sample_t sent[$];

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  asf_sample_buffer u_asf_sample_buffer (.ref_clk, .srst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .activeMode, .sleepActive, .normalRateTick, .sleepRateTick,
    .autoRateChange, .accelSample, .triggerEvent, .hostRead, .burstEnd, .axisData,
    .axisValid, .sampleCount, .overflowFlag, .watermarkFlag, .triggerSeen, .sampleStalled);
  asf_host_model u_asf_host_model (.ref_clk, .hostRead, .burstEnd, .axisData, .axisValid);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk("register", regRdData, exp);
    @(posedge ref_clk);
  endtask

  // One random sample on the chosen rate tick, then time for it to land.
  task automatic push(input bit slp);
    asf_sample_t s;
    s = SAMPLE_W'({$urandom(), $urandom()});
    sent.push_back(s);
    accelSample <= s;
    if (slp) sleepRateTick <= 1'b1;
    else normalRateTick <= 1'b1;
    @(posedge ref_clk);
    sleepRateTick <= 1'b0;
    normalRateTick <= 1'b0;
    tick(5);
  endtask

  // Whole samples are read back and compared in arrival order.
  task automatic drain(input int from, input int n);
    for (int i = 0; i < n; i++) begin
      u_asf_host_model.got.delete();
      u_asf_host_model.rd(3, $urandom_range(2, 0));
      chk("sample", {u_asf_host_model.got[0], u_asf_host_model.got[1],
        u_asf_host_model.got[2]}, sent[from + i]);
    end
    tick(2);
  endtask

  // Index of the oldest sample still held after a run of pushes.
  function automatic int kept_from(input int total, input int keep, input bit newest);
    return newest ? total - keep : 0;
  endfunction

  // Hang guard, far above the roughly two thousand cycles the tests need.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h795d));
    tick(12);
    srst <= 1'b0;
    tick(1);
    reg_chk(ADDR_BUFFER_SETUP, BUFFER_SETUP_RESET);
    reg_wr(8'h3a, 8'hff);
    reg_chk(8'h3a, 8'h00);
    reg_chk(8'h09, 8'h00);
    $display("test reset done");
    reg_wr(8'h09, 8'h44);
    activeMode <= 1'b1;
    tick(2);
    for (int i = 0; i < 36; i++) begin
      push(1'b0);
      if (i == 2 || i == 3) chk("watermark", watermarkFlag, i == 3);
    end
    chk("count", sampleCount, 32);
    chk("overflow", overflowFlag, 1);
    chk("watermark", watermarkFlag, 1);
    drain(kept_from(36, 32, 1), 32);
    chk("count", sampleCount, 0);
    u_asf_host_model.got.delete();
    u_asf_host_model.rd(3, 0);
    chk("empty", u_asf_host_model.got[0], 0);
    $display("test circular done");
    reg_wr(8'h09, 8'h00);
    tick(1);
    chk("count", sampleCount, 0);
    chk("overflow", overflowFlag, 0);
    chk("watermark", watermarkFlag, 0);
    reg_wr(8'h09, 8'h80);
    reg_chk(8'h09, 8'h84);
    reg_wr(8'h09, 8'hc0);
    reg_chk(8'h09, 8'h84);
    sent.delete();
    repeat (34) push(1'b0);
    chk("count", sampleCount, 32);
    u_asf_host_model.got.delete();
    u_asf_host_model.rd(1, 0);
    chk("x", u_asf_host_model.got[0], sent[0].x);
    tick(2);
    chk("count", sampleCount, 31);
    drain(kept_from(34, 32, 0) + 1, 31);
    $display("test stop done");
    reg_wr(8'h09, 8'h00);
    activeMode <= 1'b0;
    reg_wr(8'h09, 8'hc3);
    activeMode <= 1'b1;
    tick(2);
    sent.delete();
    repeat (10) push(1'b0);
    chk("trigger", triggerSeen, 0);
    triggerEvent <= 1'b1;
    tick(1);
    triggerEvent <= 1'b0;
    tick(3);
    chk("count", sampleCount, 3);
    chk("trigger", triggerSeen, 1);
    repeat (40) push(1'b0);
    chk("count", sampleCount, 32);
    drain(kept_from(10, 3, 1), 32);
    $display("test trigger done");
    reg_wr(8'h09, 8'h00);
    reg_wr(8'h09, 8'h41);
    sleepActive <= 1'b1;
    push(1'b1);
    push(1'b1);
    normalRateTick <= 1'b1;
    tick(1);
    normalRateTick <= 1'b0;
    tick(5);
    chk("count", sampleCount, 2);
    autoRateChange <= 1'b1;
    tick(1);
    autoRateChange <= 1'b0;
    tick(2);
    chk("count", sampleCount, 0);
    push(1'b1);
    activeMode <= 1'b0;
    tick(2);
    reg_wr(8'h09, 8'h40);
    activeMode <= 1'b1;
    tick(2);
    chk("count", sampleCount, 0);
    reg_chk(8'h09, 8'h40);
    push(1'b1);
    push(1'b1);
    chk("count", sampleCount, 2);
    chk("watermark", watermarkFlag, 0);
    chk("stalled", sampleStalled, 0);
    $display("test rates done");
    give_verdict();
  end
endmodule
